// file: core/dct_pkg.sv
package dct_pkg;
  localparam int unsigned CHAN_W   = 5;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CNT_W    = 11;
  localparam int unsigned BASE_LSB = 10;
  localparam int unsigned STRUCT_B = 16;
  localparam int unsigned ALT_BIT  = 9;
  localparam int unsigned FIFO_D   = 4;

  typedef enum logic [2:0] {
    MODE_HALTED          = 3'h0,
    MODE_REQUEST_DRIVEN  = 3'h1,
    MODE_RUN_TO_COMPLETION = 3'h2,
    MODE_DOUBLE_BUFFER   = 3'h3,
    MODE_MEM_TASK_PRI    = 3'h4,
    MODE_MEM_TASK_ALT    = 3'h5,
    MODE_PER_TASK_PRI    = 3'h6,
    MODE_PER_TASK_ALT    = 3'h7
  } dct_mode_type;

  localparam logic [1:0] SIZE_8   = 2'h0;
  localparam logic [1:0] SIZE_16  = 2'h1;
  localparam logic [1:0] SIZE_32  = 2'h2;
  localparam logic [1:0] INC_NONE = 2'h3;

  // Control word field positions within the fetched structure
  localparam int unsigned F_MODE  = 0;
  localparam int unsigned F_CNT   = 4;
  localparam int unsigned F_ARB   = 14;
  localparam int unsigned F_SSIZE = 24;
  localparam int unsigned F_SINC  = 26;
  localparam int unsigned F_DINC  = 30;
  localparam int unsigned W_SRC   = 0;
  localparam int unsigned W_DST   = 1;
  localparam int unsigned W_CTL   = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_READ  = 3'h3,
    ST_WRITE = 3'h2,
    ST_BACK  = 3'h6,
    ST_DONE  = 3'h7
  } dct_state_type;

  typedef struct packed {
    logic                valid;
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [1:0]          size;
    logic [DATA_W-1:0]   wdata;
  } dct_bus_req_type;

  typedef struct packed {
    dct_state_type       state;
    logic [CHAN_W-1:0]   chan;
    logic                alt;
    logic [1:0]          widx;
    logic [ADDR_W-1:0]   src;
    logic [ADDR_W-1:0]   dst;
    logic [DATA_W-1:0]   ctl;
    logic [CNT_W-1:0]    left;
    logic [CNT_W-1:0]    arb_left;
    logic [(1<<CHAN_W)-1:0] enable;
    logic [(1<<CHAN_W)-1:0] alt_sel;
    logic [(1<<CHAN_W)-1:0] done;
    // Keeps a started run-to-completion channel in arbitration
    logic [(1<<CHAN_W)-1:0] run_on;
    logic [ADDR_W-1:0]   base;
    dct_bus_req_type     req;
    logic                pending;
  } dct_core_type;
endpackage

// file: core/dct_top.sv
`timescale 1ns/1ps
module dct_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wp_ff;
  logic [PW-1:0]    rp_ff;
  logic [PW:0]      cnt_ff;
  logic             push;
  logic             pop;
  assign in_ready_o  = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_ff[rp_ff];
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == PW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == PW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  // Storage needs no reset; valid comes from the count
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end
endmodule

module dct_top
  import dct_pkg::*;
#(
  parameter int unsigned CHANS = 1 << dct_pkg::CHAN_W
) (
  // Clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       NRST_I,
  // Software control
  input  wire logic [dct_pkg::ADDR_W-1:0] BASE_I,
  input  wire logic                       BASE_WE_I,
  input  wire logic [CHANS-1:0]           ENABLE_SET_I,
  input  wire logic [CHANS-1:0]           ALT_SET_I,
  input  wire logic [CHANS-1:0]           ALT_CLR_I,
  input  wire logic [dct_pkg::CHAN_W-1:0] IRQ_ROUTE_CHAN_I,
  input  wire logic                       IRQ_ROUTE_EN_I,
  // Peripheral requests
  input  wire logic [CHANS-1:0]           XFER_REQ_I,
  // System bus master
  output dct_pkg::dct_bus_req_type        BUS_REQ_O,
  input  wire logic                       BUS_READY_I,
  input  wire logic [dct_pkg::DATA_W-1:0] BUS_RDATA_I,
  // Status
  output logic [dct_pkg::ADDR_W-1:0]      BASE_O,
  output logic [CHANS-1:0]                ENABLE_O,
  output logic [CHANS-1:0]                DONE_O,
  output logic [dct_pkg::CNT_W-1:0]       REMAINING_O,
  output logic [dct_pkg::CHAN_W-1:0]      ACTIVE_CHAN_O,
  output logic                            ACTIVE_ALT_O,
  output logic                            CHANNEL_IRQ_O
);
  import dct_pkg::*;

  dct_core_type r_ff;
  dct_core_type nxt_r;
  logic [DATA_W-1:0] fifo_dout;
  logic fifo_ovalid;
  logic fifo_iready;
  logic fifo_push;
  logic fifo_pop;
  logic [ADDR_W-1:0] sptr;
  logic [CHAN_W-1:0] pick;
  logic              found;
  dct_mode_type      mode;
  logic [ADDR_W-1:0] s_step;
  logic [ADDR_W-1:0] d_step;
  logic              bus_done;

  // Four-word buffer between read and write legs
  dct_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_iready),
    .in_data_i   (BUS_RDATA_I),
    .out_valid_o (fifo_ovalid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_dout)
  );

  function automatic logic [ADDR_W-1:0] step(input logic [1:0] inc);
    step = (inc == INC_NONE) ? '0 : ADDR_W'(1) << inc;
  endfunction

  // Structure address: base, alternate half, channel slot
  assign sptr = {r_ff.base[ADDR_W-1:BASE_LSB], r_ff.alt, r_ff.chan,
                 4'h0} + ADDR_W'({r_ff.widx, 2'h0});
  assign mode     = dct_mode_type'(r_ff.ctl[F_MODE +: 3]);
  // Increment is clamped to at least the item width
  assign s_step = step((r_ff.ctl[F_SINC +: 2] != INC_NONE &&
    r_ff.ctl[F_SINC +: 2] < r_ff.ctl[F_SSIZE +: 2]) ?
    r_ff.ctl[F_SSIZE +: 2] : r_ff.ctl[F_SINC +: 2]);
  assign d_step = step((r_ff.ctl[F_DINC +: 2] != INC_NONE &&
    r_ff.ctl[F_DINC +: 2] < r_ff.ctl[F_SSIZE +: 2]) ?
    r_ff.ctl[F_SSIZE +: 2] : r_ff.ctl[F_DINC +: 2]);
  assign bus_done  = r_ff.req.valid & BUS_READY_I;
  assign fifo_push = (r_ff.state == ST_READ) & bus_done & ~r_ff.req.write;
  assign fifo_pop  = (r_ff.state == ST_WRITE) & bus_done & r_ff.req.write;

  // Lowest enabled channel with a request or a started run-to-completion run wins
  always_comb begin
    pick  = '0;
    found = 1'b0;
    for (int i = CHANS-1; i >= 0; i--) begin
      if (r_ff.enable[i] && (XFER_REQ_I[i] || r_ff.run_on[i])) begin
        pick  = CHAN_W'(i);
        found = 1'b1;
      end
    end
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = '0;
    if (BASE_WE_I) begin
      nxt_r.base = {BASE_I[ADDR_W-1:BASE_LSB], BASE_LSB'(0)};
    end
    nxt_r.alt_sel = (r_ff.alt_sel | ALT_SET_I) & ~ALT_CLR_I;
    nxt_r.enable  = r_ff.enable | ENABLE_SET_I;
    if (bus_done) begin
      nxt_r.req.valid = 1'b0;
    end
    case (r_ff.state)
      ST_IDLE: begin
        if (found) begin
          nxt_r.chan  = pick;
          nxt_r.alt   = r_ff.alt_sel[pick];
          nxt_r.widx  = 2'h0;
          nxt_r.state = ST_FETCH;
          nxt_r.req   = '{1'b1, 1'b0,
            {r_ff.base[ADDR_W-1:BASE_LSB], r_ff.alt_sel[pick], pick, 4'h0},
            SIZE_32, '0};
        end
      end
      ST_FETCH: begin
        if (bus_done) begin
          case (r_ff.widx)
            W_SRC[1:0]: nxt_r.src = BUS_RDATA_I;
            W_DST[1:0]: nxt_r.dst = BUS_RDATA_I;
            default:    nxt_r.ctl = BUS_RDATA_I;
          endcase
          if (r_ff.widx == W_CTL[1:0]) begin
            nxt_r.left = BUS_RDATA_I[F_CNT +: CNT_W];
            nxt_r.arb_left = CNT_W'(1) << BUS_RDATA_I[F_ARB +: 4];
            if (BUS_RDATA_I[F_MODE +: 3] == MODE_HALTED ||
                BUS_RDATA_I[F_CNT +: CNT_W] == '0) begin
              nxt_r.enable[r_ff.chan] = 1'b0;
              nxt_r.run_on[r_ff.chan] = 1'b0;
              nxt_r.state = ST_IDLE;
            end else begin
              // Withdrawn request must not strand a started run
              nxt_r.run_on[r_ff.chan] =
                (BUS_RDATA_I[F_MODE +: 3] == MODE_RUN_TO_COMPLETION);
              nxt_r.state = ST_READ;
            end
          end else begin
            nxt_r.widx = r_ff.widx + 2'h1;
          end
        end else if (!r_ff.req.valid) begin
          // Request drops one cycle between accesses
          nxt_r.req = '{1'b1, 1'b0, sptr, SIZE_32, '0};
        end
      end
      ST_READ: begin
        if (!r_ff.req.valid && fifo_iready) begin
          nxt_r.req = '{1'b1, 1'b0, r_ff.src, r_ff.ctl[F_SSIZE +: 2], '0};
        end else if (fifo_push) begin
          nxt_r.src   = r_ff.src + s_step;
          nxt_r.state = ST_WRITE;
          nxt_r.req   = '{1'b0, 1'b0, '0, '0, '0};
        end
      end
      ST_WRITE: begin
        if (!r_ff.req.valid && fifo_ovalid) begin
          nxt_r.req = '{1'b1, 1'b1, r_ff.dst, r_ff.ctl[F_SSIZE +: 2],
                        fifo_dout};
        end else if (fifo_pop) begin
          nxt_r.dst      = r_ff.dst + d_step;
          nxt_r.left     = r_ff.left - CNT_W'(1);
          nxt_r.arb_left = r_ff.arb_left - CNT_W'(1);
          nxt_r.widx     = 2'h0;
          if (r_ff.left == CNT_W'(1)) begin
            nxt_r.state = ST_BACK;
          end else if (r_ff.arb_left == CNT_W'(1)) begin
            // Arbitration boundary: write back progress, re-arbitrate
            nxt_r.state = ST_BACK;
          end else if (mode == MODE_REQUEST_DRIVEN &&
                       !XFER_REQ_I[r_ff.chan]) begin
            nxt_r.state = ST_BACK;
          end else begin
            // Run-to-completion keeps going without the request
            nxt_r.state = ST_READ;
          end
        end
      end
      ST_BACK: begin
        // Pointers go back too, so a later fetch resumes mid-transfer
        if (!r_ff.req.valid) begin
          case (r_ff.widx)
            W_SRC[1:0]: nxt_r.req = '{1'b1, 1'b1, sptr, SIZE_32, r_ff.src};
            W_DST[1:0]: nxt_r.req = '{1'b1, 1'b1, sptr, SIZE_32, r_ff.dst};
            default: nxt_r.req = '{1'b1, 1'b1, sptr, SIZE_32,
              {r_ff.ctl[DATA_W-1:F_CNT+CNT_W], r_ff.left,
              (r_ff.left == '0) ? 1'b0 : r_ff.ctl[3],
              (r_ff.left == '0) ? MODE_HALTED : mode}};
          endcase
        end else if (bus_done) begin
          if (r_ff.widx == W_CTL[1:0]) begin
            nxt_r.state = (r_ff.left == '0) ? ST_DONE : ST_IDLE;
          end else begin
            nxt_r.widx = r_ff.widx + 2'h1;
          end
        end
      end
      ST_DONE: begin
        nxt_r.done[r_ff.chan] = 1'b1;
        nxt_r.run_on[r_ff.chan] = 1'b0;
        if (mode == MODE_DOUBLE_BUFFER || mode[2]) begin
          nxt_r.alt_sel[r_ff.chan] = ~r_ff.alt;
        end else begin
          nxt_r.enable[r_ff.chan] = 1'b0;
        end
        nxt_r.state = ST_IDLE;
      end
      default: nxt_r.state = ST_IDLE;
    endcase
  end

  // Source pointer/other fields start from a known idle state
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r_ff <= '{state: ST_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign BUS_REQ_O     = r_ff.req;
  assign BASE_O        = r_ff.base;
  assign ENABLE_O      = r_ff.enable;
  assign DONE_O        = r_ff.done;
  assign REMAINING_O   = r_ff.left;
  assign ACTIVE_CHAN_O = r_ff.chan;
  assign ACTIVE_ALT_O  = r_ff.alt;
  // Dropping the route also silences that channel
  assign CHANNEL_IRQ_O = IRQ_ROUTE_EN_I &
                         r_ff.done[IRQ_ROUTE_CHAN_I];
endmodule

// file: tb/dct_props.sv
`timescale 1ns/1ps
module dct_props
  import dct_pkg::*;
#(
  parameter int unsigned CHANS = 32
) (
  // Clock, reset and control
  input wire logic              CLK_I,
  input wire logic              NRST_I,
  input wire logic [ADDR_W-1:0] BASE_I,
  input wire logic              BASE_WE_I,
  input wire logic [CHANS-1:0]  ENABLE_SET_I,
  input wire logic [CHAN_W-1:0] IRQ_ROUTE_CHAN_I,
  input wire logic              IRQ_ROUTE_EN_I,
  // Bus and status
  input wire dct_bus_req_type   BUS_REQ_O,
  input wire logic              BUS_READY_I,
  input wire logic [ADDR_W-1:0] BASE_O,
  input wire logic [CHANS-1:0]  ENABLE_O,
  input wire logic [CHANS-1:0]  DONE_O,
  input wire logic [CNT_W-1:0]  REMAINING_O,
  input wire logic              CHANNEL_IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  a_req_hold: assert property (
    BUS_REQ_O.valid && !BUS_READY_I |=> $stable(BUS_REQ_O))
    else $error("request moved early");
  a_req_drop: assert property (
    BUS_REQ_O.valid && BUS_READY_I |=> !BUS_REQ_O.valid)
    else $error("request not dropped");
  a_irq_route: assert property (
    CHANNEL_IRQ_O == (IRQ_ROUTE_EN_I && DONE_O[IRQ_ROUTE_CHAN_I]))
    else $error("irq routing wrong");
  a_done_pulse: assert property (
    |DONE_O |=> (DONE_O & $past(DONE_O)) == '0)
    else $error("done held");
  a_en_cause: assert property (
    (ENABLE_O & ~$past(ENABLE_O) & ~$past(ENABLE_SET_I)) == '0)
    else $error("enable rose alone");
  a_base_zero: assert property (BASE_O[9:0] == 10'h000)
    else $error("base unaligned");
  a_base_load: assert property (
    BASE_WE_I |=> BASE_O[31:10] == $past(BASE_I[31:10]))
    else $error("base not loaded");
  a_idle_quiet: assert property (
    ENABLE_O == '0 && !BUS_REQ_O.valid |=> !BUS_REQ_O.valid)
    else $error("bus used while idle");
  a_done_count: assert property (
    |DONE_O |-> REMAINING_O == '0)
    else $error("count left at done");
endmodule

bind dct_top dct_props #(.CHANS(CHANS)) u_props (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .BASE_I(BASE_I),
  .BASE_WE_I(BASE_WE_I), .ENABLE_SET_I(ENABLE_SET_I),
  .IRQ_ROUTE_CHAN_I(IRQ_ROUTE_CHAN_I), .IRQ_ROUTE_EN_I(IRQ_ROUTE_EN_I),
  .BUS_REQ_O(BUS_REQ_O), .BUS_READY_I(BUS_READY_I), .BASE_O(BASE_O),
  .ENABLE_O(ENABLE_O), .DONE_O(DONE_O), .REMAINING_O(REMAINING_O),
  .CHANNEL_IRQ_O(CHANNEL_IRQ_O));

// file: tb/dct_mem_model.sv
`timescale 1ns/1ps
module dct_mem_model
  import dct_pkg::*;
(
  // Clock and reset
  input wire logic            clk_i,
  input wire logic            nrst_i,
  // Bus from the controller
  input wire dct_bus_req_type req_i,
  input wire logic [3:0]      wait_i,
  output logic                ready_o,
  output logic [DATA_W-1:0]   rdata_o
);
  logic [DATA_W-1:0] mem [0:1023];
  logic [3:0]        cnt_ff;
  logic [9:0]        idx;
  // Slow answers: wait_i idle cycles per access
  assign idx = req_i.addr[11:2];
  assign ready_o = req_i.valid && cnt_ff == wait_i;
  // Garbage outside the answer cycle, never a stale match
  assign rdata_o = ready_o ? mem[idx] : ~mem[idx];
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      cnt_ff <= 4'h0;
    else if (ready_o)
      cnt_ff <= 4'h0;
    else if (req_i.valid)
      cnt_ff <= cnt_ff + 4'h1;
  // Plain always since the bench preloads this array
  always @(posedge clk_i)
    if (ready_o && req_i.write)
      mem[idx] <= req_i.wdata;
endmodule

// file: tb/dct_top_tb.sv
`timescale 1ns/1ps
module dct_top_tb;
  import dct_pkg::*;
  logic                clk;
  logic                nrst;
  logic [ADDR_W-1:0]   base;
  logic                base_we;
  logic [31:0]         en_set;
  logic [31:0]         alt_clr;
  logic [31:0]         alt_set;
  logic [CHAN_W-1:0]   act_ch;
  logic                act_alt;
  logic [31:0]         req;
  logic [CHAN_W-1:0]   route_ch;
  logic                route_en;
  dct_bus_req_type     bus;
  logic                ready;
  logic [DATA_W-1:0]   rdata;
  logic [ADDR_W-1:0]   base_o;
  logic [31:0]         en_o;
  logic [31:0]         done_o;
  logic [CNT_W-1:0]    rem_o;
  logic                irq;
  logic                irq_seen;
  logic [3:0]          wait_cyc;
  int                  err_count;
  int                  total_checks;

  dct_top dut (
    .CLK_I(clk), .NRST_I(nrst), .BASE_I(base), .BASE_WE_I(base_we),
    .ENABLE_SET_I(en_set), .ALT_SET_I(alt_set), .ALT_CLR_I(alt_clr),
    .IRQ_ROUTE_CHAN_I(route_ch), .IRQ_ROUTE_EN_I(route_en),
    .XFER_REQ_I(req), .BUS_REQ_O(bus), .BUS_READY_I(ready),
    .BUS_RDATA_I(rdata), .BASE_O(base_o), .ENABLE_O(en_o),
    .DONE_O(done_o), .REMAINING_O(rem_o), .ACTIVE_CHAN_O(act_ch),
    .ACTIVE_ALT_O(act_alt), .CHANNEL_IRQ_O(irq));
  dct_mem_model u_mem (
    .clk_i(clk), .nrst_i(nrst), .req_i(bus), .wait_i(wait_cyc),
    .ready_o(ready), .rdata_o(rdata));

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  function automatic int sidx(input int ch, input int alt);
    return (32'h400 | alt << 9 | ch << 4) >> 2;
  endfunction
  // Word-wide items, addresses word aligned
  task automatic cfg(input int ch, input int alt, input int s,
                     input int d, input dct_mode_type m, input int n);
    u_mem.mem[sidx(ch, alt)] = s;
    u_mem.mem[sidx(ch, alt) + 1] = d;
    u_mem.mem[sidx(ch, alt) + 2] = 32'h8A00_0000 | (n << F_CNT) | m;
  endtask
  task automatic wait_done(input int ch);
    int n;
    n = 0;
    irq_seen = 1'b0;
    while (done_o[ch] !== 1'b1) begin
      @(negedge clk);
      irq_seen |= (irq === 1'b1);
      n++;
      if (n > 600) begin
        chk(1'b0, "done wait ran out");
        print_verdict();
      end
    end
  endtask
  task automatic no_bus(input int n);
    repeat (n) begin
      @(negedge clk);
      chk(bus.valid !== 1'b1, "bus access");
    end
  endtask
  task automatic chk_copy(input int d, input int s, input int n);
    for (int i = 0; i < n; i++)
      chk(u_mem.mem[d + i] === 32'hA000_0000 + s + i, "item wrong");
  endtask

  task automatic t_auto();
    cfg(0, 0, 32'h100, 32'h200, MODE_RUN_TO_COMPLETION, 3);
    route_en = 1'b1;
    wait_cyc = 4'h2;
    @(negedge clk);
    en_set[0] = 1'b1;
    req[0] = 1'b1;
    @(negedge clk);
    en_set[0] = 1'b0;
    @(negedge clk);
    req[0] = 1'b0;
    wait_done(0);
    chk(irq_seen === 1'b1, "routed irq missing");
    repeat (2) @(negedge clk);
    chk(en_o[0] === 1'b0, "enable kept");
    chk_copy(128, 64, 3);
    chk(u_mem.mem[131] === 32'hA000_0083, "extra item");
    chk(u_mem.mem[sidx(0, 0) + 2][14:0] === 15'h0, "not halted");
    $display("test auto done");
  endtask
  task automatic t_refuse();
    cfg(1, 0, 32'h100, 32'h280, MODE_RUN_TO_COMPLETION, 2);
    req[1] = 1'b1;
    no_bus(20);
    cfg(1, 0, 32'h100, 32'h280, MODE_HALTED, 2);
    en_set[1] = 1'b1;
    @(negedge clk);
    en_set[1] = 1'b0;
    repeat (40) @(negedge clk);
    chk(en_o[1] === 1'b0, "halted kept enable");
    chk(u_mem.mem[160] === 32'hA000_00A0, "halted moved");
    req[1] = 1'b0;
    $display("test refuse done");
  endtask
  task automatic t_basic();
    cfg(2, 0, 32'h100, 32'h300, MODE_REQUEST_DRIVEN, 2);
    route_en = 1'b0;
    wait_cyc = 4'h0;
    en_set[2] = 1'b1;
    @(negedge clk);
    en_set[2] = 1'b0;
    no_bus(20);
    req[2] = 1'b1;
    wait_done(2);
    chk(irq_seen === 1'b0, "unrouted irq");
    repeat (2) @(negedge clk);
    chk(en_o[2] === 1'b0, "enable kept");
    chk_copy(192, 64, 2);
    req[2] = 1'b0;
    $display("test basic done");
  endtask
  task automatic t_pingpong();
    int n;
    cfg(3, 0, 32'h100, 32'h340, MODE_DOUBLE_BUFFER, 2);
    cfg(3, 1, 32'h108, 32'h350, MODE_DOUBLE_BUFFER, 2);
    wait_cyc = 4'h3;
    alt_clr[3] = 1'b1;
    en_set[3] = 1'b1;
    req[3] = 1'b1;
    @(negedge clk);
    alt_clr[3] = 1'b0;
    en_set[3] = 1'b0;
    wait_done(3);
    repeat (2) @(negedge clk);
    chk(en_o[3] === 1'b1, "swap stopped");
    wait_done(3);
    chk_copy(208, 64, 2);
    chk_copy(212, 66, 2);
    chk(u_mem.mem[sidx(3, 1) + 2][14:0] === 15'h0, "not halted");
    for (n = 0; n < 300 && en_o[3] !== 1'b0; n++)
      @(negedge clk);
    chk(en_o[3] === 1'b0, "halted half ran");
    req[3] = 1'b0;
    $display("test pingpong done");
  endtask
  task automatic t_alt();
    cfg(4, 0, 32'h100, 32'h3C0, MODE_HALTED, 1);
    cfg(4, 1, 32'h100, 32'h380, MODE_RUN_TO_COMPLETION, 1);
    route_ch = 5'h04;
    route_en = 1'b1;
    alt_set[4] = 1'b1;
    en_set[4] = 1'b1;
    req[4] = 1'b1;
    @(negedge clk);
    alt_set[4] = 1'b0;
    en_set[4] = 1'b0;
    wait_done(4);
    chk(irq_seen === 1'b1, "routed irq missing");
    chk(act_ch === 5'h04 && act_alt === 1'b1, "wrong structure");
    chk(rem_o === 11'h000, "count left");
    chk_copy(224, 64, 1);
    chk(u_mem.mem[240] === 32'hA000_00F0, "primary used");
    chk(u_mem.mem[sidx(4, 1) + 2][14:0] === 15'h0, "not halted");
    req[4] = 1'b0;
    $display("test alternate done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {nrst, base_we, base, en_set, alt_clr, alt_set, req, route_en} = '0;
    {route_ch, wait_cyc, err_count, total_checks} = '0;
    for (int i = 0; i < 1024; i++)
      u_mem.mem[i] = 32'hA000_0000 + i;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    base = 32'h0000_04FF;
    base_we = 1'b1;
    @(negedge clk);
    base_we = 1'b0;
    chk(base_o === 32'h0000_0400, "base not masked");
    t_auto();
    t_refuse();
    t_basic();
    t_pingpong();
    t_alt();
    print_verdict();
  end
endmodule
